// ==== rtl/ciamc_pkg.sv ====
// Constants and types for the CAN interrupt identifier and message center control block
// Functional notes
// - Recessive driven but dominant sampled while transmitting, outside arbitration, is a bit-one error.
// - Dominant driven but recessive sampled while transmitting, outside arbitration, is a bit-zero error.
// - Each recessive bit received during bus-off recovery raises a bit-zero error.
// - An unacknowledged remote request sent by us is a transmit-not-acknowledged error.
// - Computed CRC differing from the received CRC is a CRC error.
// - Identifier codes: 00h none, 01h status, 02h center 15, 03h-10h centers 1-14.
// - The identifier clears to 00h on reset.
// - The identifier holds until its own source is removed, whatever else arrives.
// - Simultaneous sources load the code of the higher priority one.
// - Interrupt request is active whenever the identifier is nonzero and bit 5 of the extended enable register is set.
// - When the shown source clears, show the highest still active source or zero.
// - Status source needs a change, its matching enable, and the pending status state.
// - A center is a source exactly while its interrupt request flag is set.
// - Receive error count is read-only here; transmit error count writes load it too.
// - Receive error count clears on hardware reset and on CAN soft reset.
// - CAN interrupt enable bit 5 of the extended enable register gates the interrupt.
// - A center whose ready bit is 0 is ignored for transmit, receive and remote requests.
// - Ready bits clear on both resets; software keeps them clear until set up.
// - With transmit enable set, a completed transmission sets the request flag; else nothing.
// - Center 15 is receive-only; its transmit interrupt enable is ignored.
// - With receive enable set, a stored reception sets the request flag; else nothing.
package ciamc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CENTERS = 15;
  localparam int NUM_SRC     = 16;
  localparam int RX_ONLY_IDX = 14;

  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] ADDR_RX_ERR      = 8'he7;
  localparam logic [7:0] ADDR_EXT_IE      = 8'he8;
  localparam logic [7:0] ADDR_CENTER_BASE = 8'heb;
  localparam logic [7:0] NUM_CENTERS_B    = 8'h0f;
  localparam int         EXT_IE_CAN_BIT   = 5;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [7:0] ID_NONE          = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // ----------------------------------------
  // Bus error codes
  // ----------------------------------------
  localparam logic [2:0] ERR_NONE      = 3'h0;
  localparam logic [2:0] ERR_STUFF     = 3'h1;
  localparam logic [2:0] ERR_FORMAT    = 3'h2;
  localparam logic [2:0] ERR_NO_ACK    = 3'h3;
  localparam logic [2:0] ERR_BIT_ONE   = 3'h4;
  localparam logic [2:0] ERR_BIT_ZERO  = 3'h5;
  localparam logic [2:0] ERR_CRC       = 3'h6;
  localparam logic [2:0] ERR_UNCHANGED = 3'h7;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic ready;
    logic tx_int_enable;
    logic rx_int_enable;
    logic center_int_request;
    logic remote_request_pending;
    logic local_tx_request;
    logic overwrite_or_tx_inhibit;
    logic data_updated;
  } ciamc_center_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ciamc_sfr_req_t;

  typedef struct packed {
    logic bit_strobe;
    logic tx_active;
    logic drive_bit;
    logic sample_bit;
    logic in_arb;
    logic busoff_recovery;
    logic remote_no_ack;
    logic crc_mismatch;
    logic stuff_err;
    logic format_err;
  } ciamc_bus_obs_t;

  typedef struct packed {
    logic [NUM_CENTERS-1:0] tx_done;
    logic [NUM_CENTERS-1:0] rx_stored;
    logic [NUM_CENTERS-1:0] remote_req;
    logic [NUM_CENTERS-1:0] remote_served;
  } ciamc_engine_ev_t;

endpackage

// ==== rtl/ciamc_prio_enc.sv ====
// Priority encoder from interrupt sources to identifier code
`timescale 1ns/1ps
module ciamc_prio_enc (
  input  wire logic [ciamc_pkg::NUM_SRC-1:0] i_src,
  output logic      [7:0]                    o_code
);

  // Lowest index wins; code is index plus one
  always_comb begin
    o_code = ciamc_pkg::ID_NONE;
    for (int k = ciamc_pkg::NUM_SRC - 1; k >= 0; k--) begin
      if (i_src[k]) begin
        o_code = 8'(k + 1);
      end
    end
  end

endmodule

// ==== rtl/ciamc_top.sv ====
// CAN interrupt identifier, bus error class and message center control
`timescale 1ns/1ps
module ciamc_top (
  input  wire logic                              i_mclk,
  input  wire logic                              i_nrst,
  input  wire logic                              i_can_soft_reset,
  input  wire ciamc_pkg::ciamc_sfr_req_t         i_sfr,
  input  wire logic                              i_tec_write,
  input  wire logic                              i_rx_err_update,
  input  wire logic [7:0]                        i_rx_err_value,
  input  wire logic                              i_status_read,
  input  wire logic                              i_status_change_err,
  input  wire logic                              i_status_change_sts,
  input  wire logic                              i_error_int_enable,
  input  wire logic                              i_status_int_enable,
  input  wire ciamc_pkg::ciamc_bus_obs_t         i_bus,
  input  wire ciamc_pkg::ciamc_engine_ev_t       i_engine,
  output logic      [7:0]                        o_sfr_rdata,
  output logic      [7:0]                        o_interrupt_source_id,
  output logic                                   o_can_irq,
  output logic      [2:0]                        o_bus_error,
  output logic      [ciamc_pkg::NUM_CENTERS-1:0] o_center_ready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ciamc_pkg::ciamc_center_t                centers      [ciamc_pkg::NUM_CENTERS];
  ciamc_pkg::ciamc_center_t                next_centers [ciamc_pkg::NUM_CENTERS];

  logic [7:0]                              receive_error_count;
  logic [7:0]                              next_receive_error_count;

  logic [7:0]                              extended_int_enable_reg;
  logic [7:0]                              next_extended_int_enable_reg;

  logic [2:0]                              bus_error;
  logic [2:0]                              next_bus_error;

  logic                                    status_pend;
  logic                                    next_status_pend;

  logic [7:0]                              interrupt_source_id;
  logic [7:0]                              next_interrupt_source_id;

  logic                                    can_irq;
  logic                                    next_can_irq;

  logic [7:0]                              sfr_rdata;
  logic [7:0]                              next_sfr_rdata;

  // ----------------------------------------
  // Decode and source nets
  // ----------------------------------------
  logic [ciamc_pkg::NUM_SRC-1:0]           src;
  logic [7:0]                              best_code;
  logic [7:0]                              center_idx;
  logic                                    center_hit;
  logic                                    rx_err_sel;
  logic                                    ext_ie_sel;
  logic                                    ext_ie_wr;
  logic                                    err_loaded;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign center_idx = i_sfr.addr - ciamc_pkg::ADDR_CENTER_BASE;
  assign center_hit = (i_sfr.addr >= ciamc_pkg::ADDR_CENTER_BASE) &&
                      (center_idx < ciamc_pkg::NUM_CENTERS_B);
  assign rx_err_sel = (i_sfr.addr == ciamc_pkg::ADDR_RX_ERR);
  assign ext_ie_sel = (i_sfr.addr == ciamc_pkg::ADDR_EXT_IE);
  assign ext_ie_wr  = i_sfr.wr && ext_ie_sel;

  // ----------------------------------------
  // Bus error classification
  // ----------------------------------------
  // Only the first error after a status read is kept, so software never
  // loses a report it has not yet seen.
  always_comb begin
    logic       bit_one;
    logic       tx_zero;
    logic       boff_zero;
    logic       bit_zero;
    logic       open_slot;
    logic [2:0] code;
    bit_one   = 1'b0;
    tx_zero   = 1'b0;
    boff_zero = 1'b0;
    bit_zero  = 1'b0;
    open_slot = 1'b0;
    code      = ciamc_pkg::ERR_NONE;
    bit_one   = i_bus.bit_strobe && i_bus.tx_active && i_bus.drive_bit &&
                !i_bus.sample_bit && !i_bus.in_arb;
    tx_zero   = i_bus.bit_strobe && i_bus.tx_active && !i_bus.drive_bit &&
                i_bus.sample_bit && !i_bus.in_arb;
    boff_zero = i_bus.bit_strobe && i_bus.busoff_recovery && i_bus.sample_bit;
    bit_zero  = tx_zero || boff_zero;
    if (bit_zero) begin
      code = ciamc_pkg::ERR_BIT_ZERO;
    end else if (i_bus.stuff_err) begin
      code = ciamc_pkg::ERR_STUFF;
    end else if (i_bus.crc_mismatch) begin
      code = ciamc_pkg::ERR_CRC;
    end else if (i_bus.remote_no_ack) begin
      code = ciamc_pkg::ERR_NO_ACK;
    end else if (i_bus.format_err) begin
      code = ciamc_pkg::ERR_FORMAT;
    end else if (bit_one) begin
      code = ciamc_pkg::ERR_BIT_ONE;
    end
    open_slot = (bus_error == ciamc_pkg::ERR_NONE) ||
                (bus_error == ciamc_pkg::ERR_UNCHANGED) || i_status_read;
    err_loaded = (code != ciamc_pkg::ERR_NONE) && open_slot;
    if (err_loaded) begin
      next_bus_error = code;
    end else if (i_status_read) begin
      next_bus_error = ciamc_pkg::ERR_UNCHANGED;
    end else begin
      next_bus_error = bus_error;
    end
    if (i_can_soft_reset) begin
      next_bus_error = ciamc_pkg::ERR_NONE;
      err_loaded     = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_error <= ciamc_pkg::ERR_NONE;
    end else begin
      bus_error <= next_bus_error;
    end
  end

  // ----------------------------------------
  // Status change source
  // ----------------------------------------
  // A new change wins over a status read in the same cycle.
  always_comb begin
    next_status_pend = status_pend && !i_status_read;
    if (((err_loaded || i_status_change_err) && i_error_int_enable) ||
        (i_status_change_sts && i_status_int_enable)) begin
      next_status_pend = 1'b1;
    end
    if (i_can_soft_reset) begin
      next_status_pend = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_pend <= 1'b0;
    end else begin
      status_pend <= next_status_pend;
    end
  end

  // ----------------------------------------
  // Message centers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ciamc_pkg::NUM_CENTERS; gi++) begin : g_center
      logic center_wr;

      assign center_wr = i_sfr.wr && center_hit && (center_idx == 8'(gi));

      always_comb begin
        ciamc_pkg::ciamc_center_t c;
        ciamc_pkg::ciamc_center_t w;
        c = centers[gi];
        w = ciamc_pkg::ciamc_center_t'(i_sfr.wdata);
        if (center_wr) begin
          c.ready                   = w.ready;
          c.tx_int_enable           = w.tx_int_enable;
          c.rx_int_enable           = w.rx_int_enable;
          c.center_int_request      = w.center_int_request;
          c.remote_request_pending  = centers[gi].remote_request_pending && w.remote_request_pending;
          c.local_tx_request        = w.local_tx_request;
          c.overwrite_or_tx_inhibit = w.overwrite_or_tx_inhibit;
          c.data_updated            = w.data_updated;
        end
        // Hardware events come after the write so they win over it, whether they set or clear
        if (centers[gi].ready) begin
          if (i_engine.rx_stored[gi]) begin
            c.data_updated = 1'b1;
            if (centers[gi].rx_int_enable) begin
              c.center_int_request = 1'b1;
            end
          end
          if (i_engine.tx_done[gi] && (gi != ciamc_pkg::RX_ONLY_IDX)) begin
            c.local_tx_request = 1'b0;
            if (centers[gi].tx_int_enable) begin
              c.center_int_request = 1'b1;
            end
          end
          if (i_engine.remote_served[gi]) begin
            c.remote_request_pending = 1'b0;
          end
          if (i_engine.remote_req[gi]) begin
            c.remote_request_pending = 1'b1;
          end
        end
        if (i_can_soft_reset) begin
          c = ciamc_pkg::ciamc_center_t'(ciamc_pkg::RESET_BYTE);
        end
        next_centers[gi] = c;
      end

      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          centers[gi] <= ciamc_pkg::ciamc_center_t'(ciamc_pkg::RESET_BYTE);
        end else begin
          centers[gi] <= next_centers[gi];
        end
      end

      assign o_center_ready[gi] = centers[gi].ready;
    end
  endgenerate

  // ----------------------------------------
  // Error count and enable registers
  // ----------------------------------------
  always_comb begin
    next_receive_error_count = receive_error_count;
    if (i_rx_err_update) begin
      next_receive_error_count = i_rx_err_value;
    end
    if (i_tec_write) begin
      next_receive_error_count = i_sfr.wdata;
    end
    if (i_can_soft_reset) begin
      next_receive_error_count = ciamc_pkg::RESET_BYTE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      receive_error_count <= ciamc_pkg::RESET_BYTE;
    end else begin
      receive_error_count <= next_receive_error_count;
    end
  end

  always_comb begin
    next_extended_int_enable_reg = extended_int_enable_reg;
    if (ext_ie_wr) begin
      next_extended_int_enable_reg = i_sfr.wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      extended_int_enable_reg <= ciamc_pkg::RESET_BYTE;
    end else begin
      extended_int_enable_reg <= next_extended_int_enable_reg;
    end
  end

  // ----------------------------------------
  // Pending sources
  // ----------------------------------------
  // Sources are looked at as they will stand next cycle, so the code
  // follows a removal without a stale cycle in between.
  always_comb begin
    src[0] = next_status_pend;
    src[1] = next_centers[ciamc_pkg::RX_ONLY_IDX].center_int_request;
    for (int k = 0; k < ciamc_pkg::RX_ONLY_IDX; k++) begin
      src[k + 2] = next_centers[k].center_int_request;
    end
  end

  ciamc_prio_enc u_prio (
    .i_src  (src),
    .o_code (best_code)
  );

  // ----------------------------------------
  // Interrupt identifier
  // ----------------------------------------
  always_comb begin
    logic still;
    still = 1'b0;
    if (interrupt_source_id != ciamc_pkg::ID_NONE) begin
      still = src[4'(interrupt_source_id - 8'h01)];
    end
    if (still) begin
      next_interrupt_source_id = interrupt_source_id;
    end else begin
      next_interrupt_source_id = best_code;
    end
    next_can_irq = (next_interrupt_source_id != ciamc_pkg::ID_NONE) &&
                   next_extended_int_enable_reg[ciamc_pkg::EXT_IE_CAN_BIT];
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      interrupt_source_id <= ciamc_pkg::ID_NONE;
      can_irq             <= 1'b0;
    end else begin
      interrupt_source_id <= next_interrupt_source_id;
      can_irq             <= next_can_irq;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb begin
    next_sfr_rdata = ciamc_pkg::UNMAPPED_READ;
    if (i_sfr.rd) begin
      if (rx_err_sel) begin
        next_sfr_rdata = receive_error_count;
      end else if (ext_ie_sel) begin
        next_sfr_rdata = extended_int_enable_reg;
      end else if (center_hit) begin
        next_sfr_rdata = centers[4'(center_idx)];
      end
    end else begin
      next_sfr_rdata = sfr_rdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sfr_rdata <= ciamc_pkg::RESET_BYTE;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_sfr_rdata           = sfr_rdata;
  assign o_interrupt_source_id = interrupt_source_id;
  assign o_can_irq             = can_irq;
  assign o_bus_error           = bus_error;

endmodule

// ==== testbench/ciamc_bus_node.sv ====
// Far-side CAN node model giving one bus observation per request
`timescale 1ns/1ps
module ciamc_bus_node (
  input  wire logic                [2:0] i_kind,
  input  wire logic                      i_go,
  output ciamc_pkg::ciamc_bus_obs_t      o_bus
);
  // Idle bus sits recessive, as the bus termination pulls it there
  always_comb begin
    case (i_go ? i_kind : 3'h7)
      3'h0:    o_bus = 10'h380;
      3'h1:    o_bus = 10'h340;
      3'h2:    o_bus = 10'h2d0;
      3'h3:    o_bus = 10'h2c4;
      3'h4:    o_bus = 10'h2c8;
      3'h5:    o_bus = 10'h3a0;
      default: o_bus = 10'h0c0;
    endcase
  end
endmodule

// ==== testbench/ciamc_top_bench.sv ====
// Self-checking bench for the CAN interrupt identifier block
`timescale 1ns/1ps
module ciamc_top_bench;
  logic                         clk = 1'b0;
  logic                         nrst = 1'b0;
  logic                         srst = 1'b0;
  logic                         tecw = 1'b0;
  logic                         rxu = 1'b0;
  logic                         sread = 1'b0;
  logic                         sts = 1'b0;
  logic                         sie = 1'b0;
  logic                         extended_interrupt_enable = 1'b0;
  logic                         go = 1'b0;
  logic [2:0]                   kind = 3'h0;
  logic [7:0]                   rxv = 8'h00;
  logic [7:0]                   v;
  ciamc_pkg::ciamc_sfr_req_t    sfr = '0;
  ciamc_pkg::ciamc_engine_ev_t  eng = '0;
  ciamc_pkg::ciamc_bus_obs_t    bus;
  logic [7:0]                   rdata;
  logic [7:0]                   id;
  logic                         irq;
  logic [2:0]                   berr;
  logic [14:0]                  rdy;
  int                           num_errors = 0;
  int                           total_checks = 0;

  always #2 clk = ~clk;

  ciamc_bus_node u_ciamc_bus_node (.i_kind(kind), .i_go(go), .o_bus(bus));
  ciamc_top u_ciamc_top (.i_mclk(clk), .i_nrst(nrst), .i_can_soft_reset(srst), .i_sfr(sfr),
    .i_tec_write(tecw), .i_rx_err_update(rxu), .i_rx_err_value(rxv), .i_status_read(sread),
    .i_status_change_err(sts), .i_status_change_sts(sts), .i_error_int_enable(extended_interrupt_enable),
    .i_status_int_enable(sie), .i_bus(bus), .i_engine(eng), .o_sfr_rdata(rdata),
    .o_interrupt_source_id(id), .o_can_irq(irq), .o_bus_error(berr), .o_center_ready(rdy));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every access idles one cycle after, so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{a, 1'b1, 1'b0, d};
    tick(1);
    sfr = '0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr = '{a, 1'b0, 1'b1, 8'h00};
    tick(1);
    sfr = '0;
    tick(1);
    v = rdata;
  endtask
  task automatic ev(input ciamc_pkg::ciamc_engine_ev_t e);
    eng = e;
    tick(1);
    eng = '0;
    tick(1);
  endtask
  task automatic cid(input logic [7:0] e, input logic q);
    tick(1);
    check({id, 7'h00, irq}, {e, 7'h00, q});
  endtask
  task automatic err(input logic [2:0] k, input logic [2:0] e);
    kind = k;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(1);
    check({13'h0000, berr}, {13'h0000, e});
  endtask
  task automatic rd_status;
    sread = 1'b1;
    tick(1);
    sread = 1'b0;
    tick(1);
  endtask
  function automatic logic [14:0] c(input int n);
    return 15'h0001 << (n - 1);
  endfunction
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    tick(1);
    check({id, irq, berr, 4'h0}, 16'h0000);
    check({1'b0, rdy}, 16'h0000);
    for (int a = 8'he7; a <= 8'hf9; a++) begin
      rd(8'(a));
      check({8'h00, v}, 16'h0000);
    end
    wr(8'he8, 8'h20);
    rd(8'he8);
    check({8'h00, v}, 16'h0020);
    rxv = 8'h05;
    rxu = 1'b1;
    tick(1);
    rxu = 1'b0;
    wr(8'he7, 8'hff);
    rd(8'he7);
    check({8'h00, v}, 16'h0005);
    sfr.wdata = 8'h3c;
    tecw = 1'b1;
    tick(1);
    tecw = 1'b0;
    sfr = '0;
    rd(8'he7);
    check({8'h00, v}, 16'h003c);
    wr(8'hed, 8'h20);
    ev('{15'h0, c(3), 15'h0, 15'h0});
    cid(8'h00, 1'b0);
    for (int n = 1; n <= 15; n++) begin
      wr(8'(8'heb + n - 1), 8'ha0);
      ev('{15'h0, c(n), 15'h0, 15'h0});
      cid((n == 15) ? 8'h02 : 8'(n + 2), 1'b1);
      wr(8'(8'heb + n - 1), 8'ha0);
      cid(8'h00, 1'b0);
    end
    wr(8'he8, 8'h00);
    ev('{15'h0, c(2), 15'h0, 15'h0});
    cid(8'h04, 1'b0);
    wr(8'he8, 8'h20);
    cid(8'h04, 1'b1);
    wr(8'hec, 8'ha0);
    ev('{15'h0, c(1) | c(14), 15'h0, 15'h0});
    cid(8'h03, 1'b1);
    ev('{15'h0, c(15), 15'h0, 15'h0});
    cid(8'h03, 1'b1);
    wr(8'heb, 8'ha0);
    cid(8'h02, 1'b1);
    wr(8'hf9, 8'ha0);
    cid(8'h10, 1'b1);
    wr(8'hf8, 8'ha0);
    wr(8'hec, 8'hc0);
    ev('{c(2), 15'h0, 15'h0, 15'h0});
    cid(8'h04, 1'b1);
    wr(8'hec, 8'h80);
    ev('{c(2), 15'h0, 15'h0, 15'h0});
    cid(8'h00, 1'b0);
    wr(8'hf9, 8'hc0);
    ev('{c(15), 15'h0, 15'h0, 15'h0});
    cid(8'h00, 1'b0);
    wr(8'hed, 8'h80);
    ev('{15'h0, 15'h0, c(3), 15'h0});
    rd(8'hed);
    check({8'h00, v & 8'h08}, 16'h0008);
    ev('{15'h0, 15'h0, 15'h0, c(3)});
    rd(8'hed);
    check({8'h00, v & 8'h08}, 16'h0000);
    sts = 1'b1;
    tick(1);
    sts = 1'b0;
    cid(8'h00, 1'b0);
    sie = 1'b1;
    sts = 1'b1;
    tick(1);
    sts = 1'b0;
    cid(8'h01, 1'b1);
    rd_status();
    cid(8'h00, 1'b0);
    extended_interrupt_enable = 1'b1;
    err(3'h0, ciamc_pkg::ERR_BIT_ONE);
    cid(8'h01, 1'b1);
    rd_status();
    extended_interrupt_enable = 1'b0;
    err(3'h5, ciamc_pkg::ERR_UNCHANGED);
    err(3'h1, ciamc_pkg::ERR_BIT_ZERO);
    err(3'h3, ciamc_pkg::ERR_BIT_ZERO);
    rd_status();
    err(3'h3, ciamc_pkg::ERR_CRC);
    rd_status();
    err(3'h4, ciamc_pkg::ERR_NO_ACK);
    rd_status();
    err(3'h2, ciamc_pkg::ERR_BIT_ZERO);
    wr(8'heb, 8'h80);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    tick(1);
    check({1'b0, rdy}, 16'h0000);
    rd(8'he7);
    check({8'h00, v}, 16'h0000);
    give_verdict();
  end

  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule

// ==== testbench/ciamc_top_monitor.sv ====
// Concurrent checks on the CAN interrupt identifier block ports
`timescale 1ns/1ps
module ciamc_top_monitor (
  input wire logic                              i_mclk,
  input wire logic                              i_nrst,
  input wire logic                              i_can_soft_reset,
  input wire ciamc_pkg::ciamc_sfr_req_t         i_sfr,
  input wire logic                              i_status_read,
  input wire ciamc_pkg::ciamc_bus_obs_t         i_bus,
  input wire logic [7:0]                        o_interrupt_source_id,
  input wire logic                              o_can_irq,
  input wire logic [2:0]                        o_bus_error,
  input wire logic [ciamc_pkg::NUM_CENTERS-1:0] o_center_ready
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic err_open;
  logic tx_zero;
  logic tx_one;
  logic boff_zero;
  // A held error code only gives way to a status read, so nothing is lost
  assign err_open  = (o_bus_error == 3'h0) || (o_bus_error == 3'h7) || i_status_read;
  assign tx_one    = i_bus.bit_strobe && i_bus.tx_active && !i_bus.in_arb && i_bus.drive_bit && !i_bus.sample_bit;
  assign tx_zero   = i_bus.bit_strobe && i_bus.tx_active && !i_bus.in_arb && !i_bus.drive_bit && i_bus.sample_bit;
  assign boff_zero = i_bus.bit_strobe && i_bus.busoff_recovery && i_bus.sample_bit;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_err_taken;
    err_open && !i_can_soft_reset;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_bit_one_err: assert property (s_err_taken ##0 (tx_one && !boff_zero && !i_bus.stuff_err && !i_bus.crc_mismatch
    && !i_bus.remote_no_ack && !i_bus.format_err) |=> o_bus_error == ciamc_pkg::ERR_BIT_ONE)
    else $error("bit one error not reported");
  chk_bit_zero_err: assert property (s_err_taken ##0 tx_zero |=> o_bus_error == ciamc_pkg::ERR_BIT_ZERO)
    else $error("bit zero error not reported");
  chk_busoff_zero: assert property (s_err_taken ##0 boff_zero |=> o_bus_error == ciamc_pkg::ERR_BIT_ZERO)
    else $error("bus-off recessive bit not reported");
  chk_crc_err: assert property (s_err_taken ##0 (i_bus.crc_mismatch && !tx_zero && !boff_zero && !i_bus.stuff_err)
    |=> o_bus_error == ciamc_pkg::ERR_CRC)
    else $error("crc error not reported");
  chk_noack_err: assert property (s_err_taken ##0 (i_bus.remote_no_ack && !tx_zero && !boff_zero
    && !i_bus.stuff_err && !i_bus.crc_mismatch) |=> o_bus_error == ciamc_pkg::ERR_NO_ACK)
    else $error("no acknowledge error not reported");
  chk_arb_no_err: assert property ((i_bus.bit_strobe && i_bus.tx_active && i_bus.in_arb && !i_bus.busoff_recovery
    && !i_bus.stuff_err && !i_bus.crc_mismatch && !i_bus.remote_no_ack && !i_bus.format_err
    && !i_status_read && !i_can_soft_reset) |=> $stable(o_bus_error))
    else $error("error raised inside arbitration");
  chk_irq_needs_id: assert property (o_can_irq |-> o_interrupt_source_id != 8'h00)
    else $error("interrupt without identifier");
  chk_id_range: assert property (o_interrupt_source_id <= 8'h10)
    else $error("identifier outside code range");
  chk_id_holds: assert property ((o_interrupt_source_id != 8'h00 && !i_sfr.wr && !i_status_read
    && !i_can_soft_reset) |=> $stable(o_interrupt_source_id))
    else $error("identifier changed while source pending");
  chk_soft_clears: assert property (i_can_soft_reset |=> (o_interrupt_source_id == 8'h00
    && o_center_ready == '0 && o_bus_error == 3'h0))
    else $error("soft reset left state behind");
  chk_ready_write: assert property ((i_sfr.wr && i_sfr.addr >= 8'heb && i_sfr.addr <= 8'hf9 && !i_can_soft_reset)
    |=> o_center_ready[$past(i_sfr.addr) - 8'heb] == $past(i_sfr.wdata[7]))
    else $error("ready bit not written");
endmodule

bind ciamc_top ciamc_top_monitor u_ciamc_top_monitor (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_can_soft_reset(i_can_soft_reset), .i_sfr(i_sfr), .i_status_read(i_status_read), .i_bus(i_bus),
  .o_interrupt_source_id(o_interrupt_source_id), .o_can_irq(o_can_irq), .o_bus_error(o_bus_error),
  .o_center_ready(o_center_ready));
